// ### hw/icm_master.sv
`timescale 1ns/1ps
module icm_master #(
   parameter logic [15:0] HALF_CYC = 16'(icm_pkg::SCL_HALF_CYC)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // software register accesses, one-cycle strobes
   input wire logic cr_write,
   input wire icm_pkg::icm_ctrl_t cr_wdata,
   input wire logic sr1_read,
   input wire logic sr2_read,
   input wire logic dr_write,
   input wire logic [7:0] dr_wdata,
   input wire logic dr_read,
   input wire logic ten_bit_mode,
   // status and received data
   output icm_pkg::icm_stat_t status,
   output icm_pkg::icm_ctrl_t control,
   output logic [7:0] dr_rdata,
   // interrupt and dma configuration
   input wire logic [4:0] vec_upper,
   input wire logic [2:0] priority_level_field,
   input wire logic [2:0] irq_mask,
   input wire logic [2:0] pend_clr,
   input wire logic dma_suspend_on_error,
   input wire logic dma_rx_en,
   input wire logic dma_tx_en,
   input wire logic dma_done,
   input wire logic rx_eob,
   input wire logic tx_eob,
   // interrupt and dma outputs
   output logic [2:0] pend,
   output logic irq_req,
   output logic [7:0] irq_vector,
   output logic dma_req,
   // open-drain pins, enable low while driving low
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);

   // -----------------------------------------------
   // state
   // -----------------------------------------------
   icm_pkg::icm_state_t state, next_state; // sequencer
   icm_pkg::icm_phase_t phase, next_phase; // byte meaning
   icm_pkg::icm_stat_t next_status;
   icm_pkg::icm_ctrl_t next_control;
   logic [15:0] div, next_div; // half-period divider
   logic [3:0] bitn, next_bitn; // bit slot in byte
   logic [7:0] shreg, next_shreg; // shift register
   logic [7:0] txbuf, next_txbuf; // byte waiting to go out
   logic txfull, next_txfull;
   logic [7:0] next_dr_rdata;
   logic seen, next_seen; // status one read while event stood
   logic first, next_first; // next address byte is the first
   logic nostop, next_nostop; // suppress next stop event
   logic bitdrv, next_bitdrv; // pull sda low this slot
   logic scl_drv, sda_drv, next_scl_drv, next_sda_drv;
   logic [2:0] next_pend;
   logic next_irq_req, next_dma_req;
   logic [7:0] next_irq_vector;
   // synchronisers: stage two feeds stage three and logic, stage three feeds only the start and stop detect
   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic tick, start_det, stop_det, own, b, err_any, btf_rise;
   logic [2:0] ok;

   // -----------------------------------------------
   // next-value logic
   // -----------------------------------------------
   always_comb
   begin
      next_state = state;
      next_phase = phase;
      next_status = status;
      next_control = control;
      next_bitn = bitn;
      next_shreg = shreg;
      next_txbuf = txbuf;
      next_txfull = txfull;
      next_dr_rdata = dr_rdata;
      next_seen = seen;
      next_first = first;
      next_nostop = nostop;
      next_bitdrv = bitdrv;
      tick = (div == 16'h0000);
      next_div = tick ? HALF_CYC - 16'h0001 : div - 16'h0001;
      b = sda_s2;
      // bus conditions seen while scl stays high
      start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
      stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
      own = !(state inside {icm_pkg::S_LO, icm_pkg::S_HI, icm_pkg::S_IDLE,
                            icm_pkg::S_HOLD});

      // software access side: clears come first so a set below wins
      if (sr1_read && status.global_event_flag)
         next_seen = 1'b1;
      if (dr_write || dr_read || cr_write)
         next_seen = 1'b0;
      if (sr1_read)
         next_status.no_ack_flag = 1'b0;
      if (sr2_read)
      begin
         next_status.stop_detected_flag = 1'b0;
         next_status.arbitration_lost_flag = 1'b0;
         next_status.bus_error_flag = 1'b0;
      end
      if (dr_write)
      begin
         next_txbuf = dr_wdata;
         next_txfull = 1'b1;
      end
      if (seen && dr_write)
      begin
         next_status.start_sent_flag = 1'b0;
         next_status.header_sent_flag = 1'b0;
         if (status.transmitter_flag)
            next_status.byte_finished_flag = 1'b0;
      end
      if (seen && dr_read && !status.transmitter_flag)
         next_status.byte_finished_flag = 1'b0;
      if (seen && cr_write)
         next_status.address_transmitted_flag = 1'b0;
      if (dma_done)
      begin
         // dma completion stands for the data access
         next_status.byte_finished_flag = 1'b0;
         if (status.transmitter_flag)
         begin
            next_txbuf = dr_wdata;
            next_txfull = 1'b1;
         end
      end
      if (cr_write)
      begin
         // first write while disabled only enables
         next_control = control.pe ? cr_wdata : CTRL_RST_PE(cr_wdata.pe);
         if (control.stop && !cr_wdata.stop && status.byte_finished_flag)
         begin
            next_status.byte_finished_flag = 1'b0;
            next_nostop = 1'b1;
         end
      end

      // bus watch
      if (start_det)
         next_status.bus_busy = 1'b1;
      if (stop_det)
      begin
         next_status.bus_busy = 1'b0;
         next_nostop = 1'b0;
         if (!status.master_mode_flag && !nostop && control.pe)
            next_status.stop_detected_flag = 1'b1;
      end

      // sequencer
      unique case (state)
         icm_pkg::S_IDLE:
         begin
            if (control.start && !status.bus_busy && control.pe)
            begin
               next_state = icm_pkg::S_START1;
               next_txfull = 1'b0;
            end
         end
         icm_pkg::S_START1:
            if (tick)
               next_state = icm_pkg::S_START2;
         icm_pkg::S_START2:
         begin
            if (tick)
            begin
               next_status.master_mode_flag = 1'b1;
               next_status.start_sent_flag = 1'b1;
               next_control.start = 1'b0;
               next_phase = icm_pkg::PH_ADR;
               next_first = 1'b1;
               next_state = icm_pkg::S_HOLD;
            end
         end
         icm_pkg::S_HOLD:
         begin
            // scl stays low until every blocking flag is cleared or a start or stop is requested
            if (control.start)
            begin
               next_state = icm_pkg::S_RS1;
               next_txfull = 1'b0;
            end
            else if (control.stop)
               next_state = icm_pkg::S_STOP1;
            else if (!(status.start_sent_flag || status.header_sent_flag ||
                       status.address_transmitted_flag ||
                       status.byte_finished_flag || status.no_ack_flag))
            begin
               next_bitn = 4'h0;
               if (phase == icm_pkg::PH_RX)
               begin
                  next_bitdrv = 1'b0;
                  next_state = icm_pkg::S_LO;
               end
               else if (txfull)
               begin
                  next_shreg = txbuf;
                  next_txfull = 1'b0;
                  next_bitdrv = ~txbuf[7];
                  next_state = icm_pkg::S_LO;
               end
               else
                  next_status.byte_finished_flag = 1'b1;
            end
         end
         icm_pkg::S_RS1:
            if (tick)
               next_state = icm_pkg::S_RS2;
         icm_pkg::S_RS2:
            if (tick && scl_s2)
               next_state = icm_pkg::S_START1;
         icm_pkg::S_LO:
            if (tick)
               next_state = icm_pkg::S_HI;
         icm_pkg::S_HI:
         begin
            // wait out clock stretching before sampling
            if (tick && scl_s2)
            begin
               if (bitn != icm_pkg::BIT_ACK)
               begin
                  if (phase != icm_pkg::PH_RX && !bitdrv && !b)
                  begin
                     next_status.arbitration_lost_flag = 1'b1;
                     next_status.master_mode_flag = 1'b0;
                     next_state = icm_pkg::S_IDLE;
                  end
                  else
                  begin
                     next_shreg = {shreg[6:0], b};
                     next_bitn = bitn + 4'h1;
                     if (bitn == 4'h7)
                        next_bitdrv = (phase == icm_pkg::PH_RX) & control.ack;
                     else
                        next_bitdrv = (phase != icm_pkg::PH_RX) & ~shreg[6];
                     next_state = icm_pkg::S_LO;
                  end
               end
               else
               begin
                  next_state = icm_pkg::S_HOLD;
                  next_bitdrv = 1'b0;
                  next_first = 1'b0;
                  unique case (phase)
                     icm_pkg::PH_ADR:
                     begin
                        if (ten_bit_mode && first && !shreg[0] &&
                            shreg[7:3] == icm_pkg::HDR_MARK)
                        begin
                           next_status.header_sent_flag = 1'b1;
                           next_phase = icm_pkg::PH_AD2;
                        end
                        else
                        begin
                           next_status.address_transmitted_flag = 1'b1;
                           next_status.no_ack_flag = b;
                           next_status.transmitter_flag = ~shreg[0];
                           next_phase = shreg[0] ? icm_pkg::PH_RX : icm_pkg::PH_TX;
                        end
                     end
                     icm_pkg::PH_AD2:
                     begin
                        next_status.address_transmitted_flag = 1'b1;
                        next_status.no_ack_flag = b;
                        next_status.transmitter_flag = 1'b1;
                        next_phase = icm_pkg::PH_TX;
                     end
                     icm_pkg::PH_TX:
                     begin
                        next_status.byte_finished_flag = 1'b1;
                        next_status.no_ack_flag = b;
                     end
                     icm_pkg::PH_RX:
                     begin
                        next_dr_rdata = shreg;
                        next_status.byte_finished_flag = 1'b1;
                     end
                  endcase
               end
            end
         end
         icm_pkg::S_STOP1:
            if (tick)
               next_state = icm_pkg::S_STOP2;
         icm_pkg::S_STOP2:
            if (tick && scl_s2)
               next_state = icm_pkg::S_STOP3;
         icm_pkg::S_STOP3:
         begin
            if (tick)
            begin
               next_status.master_mode_flag = 1'b0;
               next_control.stop = 1'b0;
               next_state = icm_pkg::S_IDLE;
            end
         end
      endcase

      // foreign start or stop inside a byte
      if ((start_det || stop_det) && !own &&
          state inside {icm_pkg::S_LO, icm_pkg::S_HI})
      begin
         next_status.bus_error_flag = 1'b1;
         next_status.master_mode_flag = 1'b0;
         next_state = icm_pkg::S_IDLE;
      end

      // disabled: control but the stop bit and all status drop, lines released
      if (!control.pe && !cr_write)
      begin
         next_control = CTRL_RST_PE(1'b0);
         next_control.stop = control.stop;
         next_status = icm_pkg::STAT_RST;
         next_state = icm_pkg::S_IDLE;
      end

      // event summary
      next_status.global_event_flag = next_status.start_sent_flag |
         next_status.header_sent_flag | next_status.address_transmitted_flag |
         next_status.byte_finished_flag | next_status.no_ack_flag |
         next_status.stop_detected_flag | next_status.arbitration_lost_flag |
         next_status.bus_error_flag;

      // line drive, sda held one cycle while scl falls
      next_scl_drv = next_state inside {icm_pkg::S_START2, icm_pkg::S_HOLD,
         icm_pkg::S_LO, icm_pkg::S_RS1, icm_pkg::S_STOP1};
      next_sda_drv = (next_state inside {icm_pkg::S_START1, icm_pkg::S_START2,
         icm_pkg::S_STOP1, icm_pkg::S_STOP2}) |
         ((next_state inside {icm_pkg::S_LO, icm_pkg::S_HI}) & next_bitdrv);
      if (next_scl_drv && !scl_drv)
         next_sda_drv = sda_drv;

      // interrupt sources
      err_any = next_status.start_sent_flag | next_status.header_sent_flag |
         next_status.address_transmitted_flag | next_status.no_ack_flag |
         next_status.stop_detected_flag | next_status.arbitration_lost_flag |
         next_status.bus_error_flag;
      btf_rise = next_status.byte_finished_flag & ~status.byte_finished_flag;
      next_pend = pend & ~pend_clr;
      if (err_any && control.global_irq_enable)
         next_pend[icm_pkg::P_ERR] = 1'b1;
      if ((btf_rise && !next_status.transmitter_flag && !dma_rx_en &&
           control.global_irq_enable) || rx_eob)
         next_pend[icm_pkg::P_RX] = 1'b1;
      if ((btf_rise && next_status.transmitter_flag && !dma_tx_en &&
           control.global_irq_enable) || tx_eob)
         next_pend[icm_pkg::P_TX] = 1'b1;
      ok = pend & irq_mask;
      next_irq_req = (|ok) && (priority_level_field != icm_pkg::PRL_NEVER);
      if (ok[icm_pkg::P_ERR])
         next_irq_vector = {vec_upper, icm_pkg::VEC_ERR};
      else if (ok[icm_pkg::P_RX])
         next_irq_vector = {vec_upper, icm_pkg::VEC_RX};
      else
         next_irq_vector = {vec_upper, icm_pkg::VEC_TX};
      next_dma_req = status.master_mode_flag & status.byte_finished_flag & ~dma_done &
         (status.transmitter_flag ? dma_tx_en : dma_rx_en) &
         ~(dma_suspend_on_error & pend[icm_pkg::P_ERR]);
   end

   // enabling write keeps only the enable bit
   function automatic icm_pkg::icm_ctrl_t CTRL_RST_PE(input logic pe);
      icm_pkg::icm_ctrl_t c;
      c = icm_pkg::CTRL_RST;
      c.pe = pe;
      return c;
   endfunction : CTRL_RST_PE

   // -----------------------------------------------
   // registers
   // -----------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      if (reset)
      begin
         state <= icm_pkg::S_IDLE;
         phase <= icm_pkg::PH_ADR;
         status <= icm_pkg::STAT_RST;
         control <= icm_pkg::CTRL_RST;
         div <= 16'h0000;
         bitn <= 4'h0;
         shreg <= 8'h00;
         txbuf <= 8'h00;
         txfull <= 1'b0;
         dr_rdata <= 8'h00;
         seen <= 1'b0;
         first <= 1'b0;
         nostop <= 1'b0;
         bitdrv <= 1'b0;
         scl_drv <= 1'b0;
         sda_drv <= 1'b0;
         pend <= 3'h0;
         irq_req <= 1'b0;
         irq_vector <= 8'h00;
         dma_req <= 1'b0;
      end
      else
      begin
         state <= next_state;
         phase <= next_phase;
         status <= next_status;
         control <= next_control;
         div <= next_div;
         bitn <= next_bitn;
         shreg <= next_shreg;
         txbuf <= next_txbuf;
         txfull <= next_txfull;
         dr_rdata <= next_dr_rdata;
         seen <= next_seen;
         first <= next_first;
         nostop <= next_nostop;
         bitdrv <= next_bitdrv;
         scl_drv <= next_scl_drv;
         sda_drv <= next_sda_drv;
         pend <= next_pend;
         irq_req <= next_irq_req;
         irq_vector <= next_irq_vector;
         dma_req <= next_dma_req;
      end
   end

   // open-drain pins: data always low, enable low pulls the wire
   always_ff @(posedge sys_clk)
   begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= reset ? 1'b1 : ~next_scl_drv;
      sda_oe_n <= reset ? 1'b1 : ~next_sda_drv;
   end

endmodule : icm_master

// ### hw/icm_pkg.sv
// Function
// - start only while bus not busy
// - start sets master mode, start-sent, interrupt
// - hold scl until status read, data write
// - ten-bit header sets header flag, then hold
// - address sent sets flag, hold until control write
// - acknowledged address picks direction; transmitter sets byte-finished
// - arbitration loss flags, drops master, resets process
// - transmitter holds scl until data or dma
// - receiver stores byte, optional acknowledge, holds scl
// - start or stop mid-byte flags bus error
// - stop after current byte, no interrupt
// - read and write sequences clear byte events
// - status read clears no-ack; stop toggle releases
// - global event flag; interrupts need global enable, except end-of-block rx/tx
// - byte-finished with direction picks rx/tx source
// - error pending forced while error flags set
// - vector is upper bits plus source code
// - priority field; error over rx over tx
// - pending bits request while masked in
// - dma suspended by error pending when enabled
package icm_pkg;

   // -----------------------------------------------
   // timing
   // -----------------------------------------------
   localparam int CLK_NS = 25; // core clock period
   localparam int SCL_HALF_NS = 5000; // half scl period, standard speed
   localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS; // least time, round up

   // -----------------------------------------------
   // codes and positions
   // -----------------------------------------------
   localparam logic [2:0] VEC_ERR = 3'h2; // error source code
   localparam logic [2:0] VEC_RX = 3'h4; // data received code
   localparam logic [2:0] VEC_TX = 3'h6; // ready to transmit code
   localparam logic [2:0] PRL_NEVER = 3'h7; // level never acknowledged
   localparam logic [4:0] HDR_MARK = 5'h1e; // ten-bit header prefix
   localparam logic [3:0] BIT_ACK = 4'h8; // ninth slot index
   localparam int P_ERR = 0; // pending bit positions
   localparam int P_RX = 1;
   localparam int P_TX = 2;

   // software control bits
   typedef struct packed {
      logic pe;
      logic start;
      logic ack;
      logic stop;
      logic global_irq_enable;
   } icm_ctrl_t;

   // status flags
   typedef struct packed {
      logic master_mode_flag;
      logic start_sent_flag;
      logic header_sent_flag;
      logic address_transmitted_flag;
      logic byte_finished_flag;
      logic transmitter_flag;
      logic bus_busy;
      logic no_ack_flag;
      logic stop_detected_flag;
      logic arbitration_lost_flag;
      logic bus_error_flag;
      logic global_event_flag;
   } icm_stat_t;

   localparam icm_ctrl_t CTRL_RST = '0; // values after reset
   localparam icm_stat_t STAT_RST = '0;

   typedef enum {S_IDLE, S_START1, S_START2, S_HOLD, S_LO, S_HI,
                 S_RS1, S_RS2, S_STOP1, S_STOP2, S_STOP3} icm_state_t;
   typedef enum {PH_ADR, PH_AD2, PH_TX, PH_RX} icm_phase_t;

endpackage : icm_pkg

// ### test/icm_props.sv
`timescale 1ns/1ps
module icm_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // watched ports
   input wire icm_pkg::icm_stat_t status,
   input wire icm_pkg::icm_ctrl_t control,
   input wire logic [4:0] vec_upper,
   input wire logic [2:0] priority_level_field,
   input wire logic [2:0] irq_mask,
   input wire logic [2:0] pend,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector,
   input wire logic scl_oe_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence s_start_done;
      $rose(status.start_sent_flag);
   endsequence
   // any error event flag but stop-detected while interrupts are on
   sequence s_err_held;
      control.global_irq_enable && (status.start_sent_flag || status.header_sent_flag
         || status.address_transmitted_flag || status.no_ack_flag
         || status.arbitration_lost_flag || status.bus_error_flag);
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_start_mode: assert property (
      s_start_done |-> status.master_mode_flag && status.global_event_flag)
      else $error("start flag without master and event flags");
   a_err_forced: assert property (s_err_held |=> pend[icm_pkg::P_ERR])
      else $error("error pending not held by error flag");
   a_req_masked: assert property (irq_req |-> $past(|(pend & irq_mask)))
      else $error("request without masked-in pending bit");
   a_never_lvl: assert property (
      $past(priority_level_field) == icm_pkg::PRL_NEVER |-> !irq_req)
      else $error("request at never level");
   a_err_vec: assert property (
      irq_req && $past(pend[0] && irq_mask[0]) |->
      irq_vector == {$past(vec_upper), icm_pkg::VEC_ERR})
      else $error("wrong error vector");
   a_rx_vec: assert property (
      irq_req && $past(pend[1] && irq_mask[1] && !(pend[0] && irq_mask[0])) |->
      irq_vector[2:0] == icm_pkg::VEC_RX)
      else $error("wrong rx vector");
   a_start_hold: assert property (
      status.start_sent_flag && $past(status.start_sent_flag) |-> !scl_oe_n)
      else $error("clock released while start flag set");
   a_addr_hold: assert property (
      status.address_transmitted_flag && $past(status.address_transmitted_flag) |-> !scl_oe_n)
      else $error("clock released while address flag set");
   a_stop_quiet: assert property (
      $fell(status.master_mode_flag) && !status.arbitration_lost_flag
      && !status.bus_error_flag |=> !status.stop_detected_flag [*8])
      else $error("own stop flagged");
endmodule : icm_props

bind icm_master icm_props u_props (.*);

// ### test/icm_slave_model.sv
`timescale 1ns/1ps
module icm_slave_model (
   // wire levels
   input wire logic scl,
   input wire logic sda,
   // test controls
   input wire logic nack_all,
   input wire logic [7:0] tx_byte,
   // pull and captures
   output logic sda_pull,
   output logic [7:0] rx_byte,
   output logic last_ack
);
   int cnt = 0; // clock pulses in byte
   logic adr = 1'b0; // address phase
   logic rd = 1'b0; // read transfer
   logic [7:0] sh = 8'h00; // shift in
   initial sda_pull = 1'b0;
   // start or stop: reframe, release the line
   always @(sda) if (scl === 1'b1) {cnt, adr, rd, sda_pull} = {32'd0, !sda, 2'b00};
   // sample on rising clock, ninth slot is the acknowledge
   always @(posedge scl)
   begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else last_ack = sda;
      cnt = cnt + 1;
   end
   // drive after falling clock; a nack from the master ends a read
   always @(negedge scl)
   begin
      if (cnt == 8)
      begin
         if (adr) rd = sh[0];
         rx_byte = sh;
         sda_pull = !nack_all && !(rd && !adr);
      end
      else
      begin
         if (cnt == 9) {cnt, adr, rd} = {32'd0, 1'b0, rd && !last_ack};
         if (cnt < 8) sda_pull = rd && !adr && !tx_byte[3'(7 - cnt)];
      end
   end
endmodule : icm_slave_model

// ### test/i2c_master_events_irq_tb_top.sv
`timescale 1ns/1ps
module i2c_master_events_irq_tb_top;
   // status bit positions
   localparam int K_SENT = 10, K_HDR = 9, K_ADDR = 8, K_BYTE = 7, K_BUSY = 5;
   localparam int K_NACK = 4, K_STOPD = 3, K_LOST = 2;
   logic sys_clk = 0, reset = 1, cr_write = 0, sr1_read = 0, sr2_read = 0, dr_write = 0;
   logic dr_read = 0, ten_bit_mode = 0, dma_done = 0, rx_eob = 0, tx_eob = 0, jam = 0;
   logic dma_rx_en = 0, dma_tx_en = 0, dma_suspend_on_error = 1, nack_all = 0;
   logic [7:0] dr_wdata = 8'h00, tx_byte = 8'h3c, irq_vector, dr_rdata, rx_byte;
   logic [4:0] vec_upper = 5'h15;
   logic [2:0] priority_level_field = 3'h0, irq_mask = 3'h7, pend_clr = 3'h0, pend;
   logic irq_req, dma_req, scl_oe_n, sda_oe_n, sda_pull, last_ack;
   icm_pkg::icm_ctrl_t cr_wdata = '0, control;
   icm_pkg::icm_stat_t status;
   int fails = 0, num_checks = 0;
   // open-drain wires, pulled up when nobody pulls
   wire scl_w = scl_oe_n;
   wire sda_w = sda_oe_n & !sda_pull & !jam;
   initial forever #12.5 sys_clk = ~sys_clk;
   icm_master #(.HALF_CYC(16'h6)) u_dut (.*, .scl_in(scl_w), .scl_out(), .sda_in(sda_w),
      .sda_out());
   icm_slave_model u_slave (.scl(scl_w), .sda(sda_w), .nack_all(nack_all),
      .tx_byte(tx_byte), .sda_pull(sda_pull), .rx_byte(rx_byte), .last_ack(last_ack));
   // ----------------------------------------
   // access tasks: one-cycle strobes
   // ----------------------------------------
   task automatic acc(input int k, input logic [7:0] d);
      @(negedge sys_clk);
      case (k)
         0: {cr_write, cr_wdata} = {1'b1, d[4:0]};
         1: sr1_read = 1;
         2: {dr_write, dr_wdata} = {1'b1, d};
         3: dr_read = 1;
         4: sr2_read = 1;
         5: pend_clr = d[2:0];
         default: {tx_eob, rx_eob} = d[1:0];
      endcase
      @(negedge sys_clk);
      {cr_write, sr1_read, dr_write, dr_read, sr2_read, rx_eob, tx_eob, pend_clr} = 10'h000;
   endtask : acc
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // bounded wait on one status bit
   task automatic wt(input int b, input logic v);
      int n;
      n = 0;
      repeat (2) @(negedge sys_clk);
      while (status[b] !== v && n < 4000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 4000) chk("wait", 16'(b), 16'hffff);
   endtask : wt
   // open a transfer: start, address
   task automatic open_to(input logic [7:0] a);
      acc(0, 8'h19);
      wt(K_SENT, 1);
      acc(1, 8'h00);
      acc(2, a);
   endtask : open_to
   task automatic print_verdict();
      if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (10) @(negedge sys_clk);
      reset = 0;
      chk("idle", 16'h3, {status, scl_oe_n, sda_oe_n});
      acc(0, 8'h11);
      acc(0, 8'h11);
      acc(0, 8'h19);
      wt(K_SENT, 1);
      chk("start", 16'h6, {status.master_mode_flag, status.global_event_flag, scl_oe_n});
      acc(2, 8'h54);
      acc(5, 8'h01);
      repeat (30) @(negedge sys_clk);
      chk("hold", 16'h3, {status.start_sent_flag, pend[0]});
      chk("err_vec", {vec_upper, icm_pkg::VEC_ERR}, irq_vector);
      acc(1, 8'h00);
      acc(2, 8'h54);
      wt(K_ADDR, 1);
      chk("sent_clr", 16'h0, status.start_sent_flag);
      acc(1, 8'h00);
      acc(0, 8'h11);
      wt(K_BYTE, 1);
      acc(5, 8'h01);
      repeat (2) @(negedge sys_clk);
      chk("tx_vec", {8'h01, vec_upper, icm_pkg::VEC_TX}, {status.transmitter_flag, irq_vector});
      acc(1, 8'h00);
      acc(2, 8'ha5);
      wt(K_BYTE, 1);
      chk("tx_byte", 16'h00a5, rx_byte);
      acc(0, 8'h13);
      wt(11, 0);
      chk("stop", 16'h0, {status.master_mode_flag, status.stop_detected_flag, status.bus_busy});
      open_to(8'h55);
      wt(K_ADDR, 1);
      acc(1, 8'h00);
      acc(0, 8'h11);
      wt(K_BYTE, 1);
      acc(5, 8'h05);
      repeat (2) @(negedge sys_clk);
      chk("rx", {8'h3c, 4'h1, vec_upper[0], icm_pkg::VEC_RX},
         {dr_rdata, 3'h0, last_ack, irq_vector[3:0]});
      chk("rx_dir", 16'h0, status.transmitter_flag);
      acc(0, 8'h13);
      wt(11, 0);
      acc(1, 8'h00);
      acc(3, 8'h00);
      chk("rx_clr", 16'h0, status.byte_finished_flag);
      nack_all = 1;
      open_to(8'h54);
      wt(K_NACK, 1);
      acc(1, 8'h00);
      chk("nack_clr", 16'h0, status.no_ack_flag);
      acc(0, 8'h13);
      wt(K_BUSY, 0);
      nack_all = 0;
      ten_bit_mode = 1;
      open_to(8'hf0);
      wt(K_HDR, 1);
      chk("hdr_hold", 16'h0, scl_oe_n);
      acc(1, 8'h00);
      acc(2, 8'h33);
      wt(K_ADDR, 1);
      acc(1, 8'h00);
      nack_all = 1;
      open_to(8'hf1);
      wt(K_ADDR, 1);
      chk("hdr_rd", 16'h0, status.transmitter_flag);
      acc(1, 8'h00);
      acc(0, 8'h13);
      wt(K_BUSY, 0);
      {nack_all, ten_bit_mode} = 2'b00;
      acc(0, 8'h19);
      wt(K_SENT, 1);
      jam = 1;
      acc(1, 8'h00);
      acc(2, 8'h54);
      wt(K_LOST, 1);
      chk("lost", 16'h0, status.master_mode_flag);
      jam = 0;
      wt(K_STOPD, 1);
      acc(4, 8'h00);
      chk("sr2_clr", 16'h0, {status.arbitration_lost_flag, status.stop_detected_flag});
      acc(5, 8'h07);
      acc(6, 8'h03);
      priority_level_field = 3'h7;
      repeat (3) @(negedge sys_clk);
      chk("eob", 16'h6, {irq_req, pend});
      priority_level_field = 3'h0;
      acc(5, 8'h07);
      repeat (3) @(negedge sys_clk);
      chk("cleared", 16'h0, {irq_req, pend});
      print_verdict();
   end
endmodule : i2c_master_events_irq_tb_top
